//--- rtl/ssx_txrx_core.sv
// ssx_txrx_core: full-duplex 8-bit clocked serial port with stop control
// and transmit underrun / receive overrun handling
// assumes an avalon-mm master on sys_clk_i and a peer sharing the serial clock
`timescale 1ns/100ps
`include "ssx_map.svh"
module ssx_txrx_core #(
    parameter int SCK_HALF_CYC = `SSX_SCK_HALF_DEF
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_n_o,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic ack_ff;
    logic [31:0] rdata_ff, nxt_rdata;
    logic run_ff, inh_ff, ext_ff, lsb_ff;
    logic [1:0] mode_ff;
    logic opf_ff, sef_ff, txl_ff, rxf_ff, transmit_error_flag_ff, receive_error_flag_ff, rd_once_ff;
    logic nxt_opf, nxt_sef, nxt_txl, nxt_rxf, nxt_transmit_error_flag, nxt_receive_error_flag, nxt_rd_once;
    logic [7:0] rdb_ff, tdb_ff, txsh_ff, rxsh_ff;
    logic [7:0] nxt_rdb, nxt_tdb, nxt_txsh, nxt_rxsh;
    logic [3:0] fcnt_ff, rcnt_ff, nxt_fcnt, nxt_rcnt;
    ssx_pkg::ssx_frm_t frm_ff, nxt_frm;
    logic so_ff, nxt_so, irq_ff;

    ssx_link_if lk ();

    // pin sampling and edge finding
    // the edge finder owns both synchronisers; nothing here reads a raw pin
    ssx_sck_edge #(
        .SCK_HALF_CYC(SCK_HALF_CYC)
    ) u_edge (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .sck_pin_i(sck_i),
        .sdi_pin_i(sdi_i),
        .sck_o(sck_o),
        .lk(lk)
    );

    ////////////////////////////////////////////////////////////////////////////
    // avalon decode: one wait cycle, then the access is accepted
    // read data are taken from a settled address; the price is a wait per access
    // only byte lane 0 carries register bits, the other lanes are ignored
    wire logic req = avs_read_i | avs_write_i;
    wire logic acc = req & ack_ff & ce_i;
    wire logic wr_ctrl = acc & avs_write_i & avs_byteenable_i[0] &
        (avs_address_i == `SSX_OFF_CTRL);
    wire logic wr_txb = acc & avs_write_i & avs_byteenable_i[0] &
        (avs_address_i == `SSX_OFF_TXB);
    wire logic rd_rxb = acc & avs_read_i & (avs_address_i == `SSX_OFF_RXB);
    wire logic inh_now = wr_ctrl & avs_writedata_i[`SSX_C_INH];

    assign avs_waitrequest_o = req & ~(ack_ff & ce_i);
    assign avs_readdata_o = rdata_ff;

    // frame event decode
    // pin edges show up three to four system clocks late, so each half of
    // the peer's clock must be longer than that or bits are missed
    wire logic go = run_ff & ~inh_ff & (mode_ff == `SSX_MODE_TXRX);
    wire logic idle = (frm_ff == ssx_pkg::SSX_FRM_IDLE);
    wire logic start = lk.fall & idle & go;
    wire logic mid_fall = lk.fall & ~idle & (fcnt_ff < `SSX_BITS);
    wire logic samp = lk.rise & ~idle & (rcnt_ff < fcnt_ff);
    wire logic done = samp & (rcnt_ff == `SSX_LAST_BIT);
    // overrun is only possible with the peer's clock; the internal one waits
    wire logic rx_over = done & rxf_ff & ext_ff & ~receive_error_flag_ff;
    wire logic rx_keep = done & ~receive_error_flag_ff & ~rx_over;
    // an underrun still runs a whole frame of ones, so the peer stays in step
    wire logic under = start & ~txl_ff;
    // run cleared between frames: nothing is in flight, so the stop is immediate
    wire logic stop_idle = idle & ~run_ff;
    wire logic [7:0] rx_shifted = lsb_ff ? {lk.sdi, rxsh_ff[7:1]} : {rxsh_ff[6:0], lk.sdi};
    // after a receive error the second read shows the frozen shift register
    wire logic rd_sel_sh = receive_error_flag_ff & rd_once_ff;

    // internal clock runs a started frame to its end, and waits for both
    // buffers before a new one; that auto-wait keeps errors to external mode
    // the generator stops only at its high level, so sck never ends short
    assign lk.gen_en = ~ext_ff & ((~idle & ~inh_ff) | (go & txl_ff & ~rxf_ff));
    assign lk.ext_mode = ext_ff;
    assign sck_oe_n_o = ext_ff;
    // serial data come from a flop, so they cannot glitch between falling edges
    assign sdo_o = so_ff;
    assign irq_o = irq_ff;

    // transmit bit picker for either bit order
    // the index wraps on three bits; only counts below eight reach it
    function automatic logic bit_of(input logic [7:0] d, input logic [3:0] i,
                                    input logic lsb);
        bit_of = lsb ? d[i[2:0]] : d[`SSX_MSB_IDX - i[2:0]];
    endfunction : bit_of

    ////////////////////////////////////////////////////////////////////////////
    // read data mux, captured in the wait cycle so it stands at acceptance
    // reads of the receive buffer act only at acceptance, not in the wait cycle
    always_comb begin
        nxt_rdata = `SSX_WORD_RST;
        unique case (avs_address_i)
            `SSX_OFF_CTRL: begin
                nxt_rdata[`SSX_C_RUN] = run_ff;
                nxt_rdata[`SSX_C_INH] = inh_ff;
                nxt_rdata[`SSX_C_MODE] = mode_ff;
                nxt_rdata[`SSX_C_EXT] = ext_ff;
                nxt_rdata[`SSX_C_LSB] = lsb_ff;
            end
            `SSX_OFF_STAT: begin
                nxt_rdata[`SSX_S_OPF] = opf_ff;
                nxt_rdata[`SSX_S_SEF] = sef_ff;
                nxt_rdata[`SSX_S_TXE] = ~txl_ff;
                nxt_rdata[`SSX_S_RXF] = rxf_ff;
                nxt_rdata[`SSX_S_TRANSMIT_ERROR_FLAG] = transmit_error_flag_ff;
                nxt_rdata[`SSX_S_RECEIVE_ERROR_FLAG] = receive_error_flag_ff;
            end
            `SSX_OFF_RXB: nxt_rdata[7:0] = rd_sel_sh ? rxsh_ff : rdb_ff;
            default: nxt_rdata = `SSX_WORD_RST; // unmapped reads as zero
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // flag and data next state: bus clears first, link events after, so a
    // set in the same cycle as a clear wins; inhibit overrides everything
    // order matters below: a later assignment overrides an earlier one
    always_comb begin
        nxt_opf = opf_ff;
        nxt_sef = sef_ff;
        nxt_txl = txl_ff;
        nxt_rxf = rxf_ff;
        nxt_transmit_error_flag = transmit_error_flag_ff;
        nxt_receive_error_flag = receive_error_flag_ff;
        nxt_rd_once = rd_once_ff;
        nxt_rdb = rdb_ff;
        nxt_tdb = tdb_ff;
        nxt_txsh = txsh_ff;
        nxt_rxsh = rxsh_ff;
        nxt_fcnt = fcnt_ff;
        nxt_rcnt = rcnt_ff;
        nxt_frm = frm_ff;
        nxt_so = so_ff;
        // receive buffer reads
        if (rd_rxb) begin
            if (!receive_error_flag_ff) begin
                nxt_rxf = 1'b0;
            end else if (!rd_once_ff) begin
                nxt_rd_once = 1'b1;
            end else begin
                nxt_receive_error_flag = 1'b0;
                nxt_rxf = 1'b0;
                nxt_rd_once = 1'b0;
            end
        end
        // first falling edge: load transmit byte, raise busy and shift flags
        if (start) begin
            nxt_frm = ssx_pkg::SSX_FRM_SHIFT;
            nxt_opf = 1'b1;
            nxt_sef = 1'b1;
            nxt_fcnt = `SSX_CNT_ONE;
            nxt_txsh = tdb_ff;
            nxt_txl = 1'b0;
            nxt_so = bit_of(tdb_ff, `SSX_CNT_ZERO, lsb_ff);
            if (under) begin
                nxt_transmit_error_flag = 1'b1;
            end
        end
        // later falling edges shift out; the eighth drops the shift flag
        if (mid_fall) begin
            nxt_fcnt = fcnt_ff + `SSX_CNT_ONE;
            nxt_so = bit_of(txsh_ff, fcnt_ff, lsb_ff);
            if (fcnt_ff == `SSX_LAST_BIT) begin
                nxt_sef = 1'b0;
            end
        end
        // rising edges sample in, unless a receive error froze the data
        if (samp) begin
            nxt_rcnt = rcnt_ff + `SSX_CNT_ONE;
            if (!receive_error_flag_ff) begin
                nxt_rxsh = rx_shifted;
            end
        end
        // eighth sample ends the frame
        if (done) begin
            nxt_frm = ssx_pkg::SSX_FRM_IDLE;
            nxt_fcnt = `SSX_CNT_ZERO;
            nxt_rcnt = `SSX_CNT_ZERO;
            if (rx_keep) begin
                nxt_rdb = rx_shifted;
                nxt_rxf = 1'b1;
            end
            if (rx_over) begin
                nxt_receive_error_flag = 1'b1;
                nxt_rd_once = 1'b0;
            end
            // run cleared during the frame: stop only now
            if (!run_ff) begin
                nxt_opf = 1'b0;
                nxt_so = 1'b1;
            end
        end
        if (stop_idle) begin
            nxt_opf = 1'b0;
            nxt_so = 1'b1;
        end
        // a byte written in the start cycle stays for the next frame
        if (wr_txb) begin
            nxt_tdb = avs_writedata_i[7:0];
            nxt_txl = 1'b1;
        end
        if (nxt_transmit_error_flag) begin
            nxt_so = 1'b1;
        end
        // inhibit: immediate stop and return to initial values
        if (inh_now) begin
            nxt_opf = 1'b0;
            nxt_sef = 1'b0;
            nxt_txl = 1'b0;
            nxt_rxf = 1'b0;
            nxt_transmit_error_flag = 1'b0;
            nxt_receive_error_flag = 1'b0;
            nxt_rd_once = 1'b0;
            nxt_rdb = `SSX_BYTE_RST;
            nxt_tdb = `SSX_BYTE_RST;
            nxt_txsh = `SSX_BYTE_RST;
            nxt_rxsh = `SSX_BYTE_RST;
            nxt_fcnt = `SSX_CNT_ZERO;
            nxt_rcnt = `SSX_CNT_ZERO;
            nxt_frm = ssx_pkg::SSX_FRM_IDLE;
            nxt_so = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake and read data
    // ack toggles, so back-to-back requests each still see one wait cycle
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack_ff <= 1'b0;
            rdata_ff <= `SSX_WORD_RST;
        end else if (ce_i) begin
            ack_ff <= req & ~ack_ff;
            if (req && !ack_ff) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // control register; inhibit forces run low in the same write
    // mode codes other than full duplex are stored but leave the port idle
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_ff <= 1'b0;
            inh_ff <= 1'b0;
            mode_ff <= `SSX_MODE_RST;
            ext_ff <= 1'b0;
            lsb_ff <= 1'b0;
        end else if (ce_i && wr_ctrl) begin
            run_ff <= avs_writedata_i[`SSX_C_RUN] & ~inh_now;
            inh_ff <= avs_writedata_i[`SSX_C_INH];
            mode_ff <= avs_writedata_i[`SSX_C_MODE];
            ext_ff <= avs_writedata_i[`SSX_C_EXT];
            lsb_ff <= avs_writedata_i[`SSX_C_LSB];
        end
    end

    // status flags
    // a low clock enable holds every flag, even in the middle of a frame
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {opf_ff, sef_ff, txl_ff, rxf_ff} <= 4'h0;
            {transmit_error_flag_ff, receive_error_flag_ff, rd_once_ff} <= 3'h0;
        end else if (ce_i) begin
            {opf_ff, sef_ff, txl_ff, rxf_ff} <= {nxt_opf, nxt_sef, nxt_txl, nxt_rxf};
            {transmit_error_flag_ff, receive_error_flag_ff, rd_once_ff} <= {nxt_transmit_error_flag, nxt_receive_error_flag, nxt_rd_once};
        end
    end

    // buffers and shift registers
    // inhibit clears these in the same cycle as its control write lands
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {rdb_ff, tdb_ff} <= {`SSX_BYTE_RST, `SSX_BYTE_RST};
            {txsh_ff, rxsh_ff} <= {`SSX_BYTE_RST, `SSX_BYTE_RST};
        end else if (ce_i) begin
            {rdb_ff, tdb_ff} <= {nxt_rdb, nxt_tdb};
            {txsh_ff, rxsh_ff} <= {nxt_txsh, nxt_rxsh};
        end
    end

    // frame sequencer, serial data out and interrupt pulse
    // irq is a one-cycle pulse; there is no pending bit for software to clear
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            frm_ff <= ssx_pkg::SSX_FRM_IDLE;
            fcnt_ff <= `SSX_CNT_ZERO;
            rcnt_ff <= `SSX_CNT_ZERO;
            so_ff <= 1'b1;
            irq_ff <= 1'b0;
        end else if (ce_i) begin
            frm_ff <= nxt_frm;
            fcnt_ff <= nxt_fcnt;
            rcnt_ff <= nxt_rcnt;
            so_ff <= nxt_so;
            irq_ff <= done & ~receive_error_flag_ff & ~inh_now;
        end
    end

endmodule : ssx_txrx_core

//--- pkg/ssx_map.svh
// ssx_map.svh: offsets, field positions, reset values and counts of the serial port
// assumes inclusion by bare name from the package search path
`ifndef SSX_MAP_SVH
`define SSX_MAP_SVH

// register byte offsets on the avalon slave
`define SSX_OFF_CTRL 4'h0
`define SSX_OFF_STAT 4'h4
`define SSX_OFF_RXB 4'h8
`define SSX_OFF_TXB 4'hC

// serial_control_reg fields
`define SSX_C_RUN 0
`define SSX_C_INH 1
`define SSX_C_MODE 3:2
`define SSX_C_EXT 4
`define SSX_C_LSB 5

// serial_status_reg fields
`define SSX_S_OPF 0
`define SSX_S_SEF 1
`define SSX_S_TXE 2
`define SSX_S_RXF 3
`define SSX_S_TRANSMIT_ERROR_FLAG 4
`define SSX_S_RECEIVE_ERROR_FLAG 5

// operating_mode_field code for full-duplex transmit/receive
`define SSX_MODE_TXRX 2'h2
`define SSX_MODE_RST 2'h0

// frame length and bit indexing
`define SSX_BITS 4'h8
`define SSX_LAST_BIT 4'h7
`define SSX_CNT_ZERO 4'h0
`define SSX_CNT_ONE 4'h1
`define SSX_MSB_IDX 3'h7

// reset values
`define SSX_BYTE_RST 8'h00
`define SSX_WORD_RST 32'h0000_0000

// internal serial clock half period in system clocks
`define SSX_SCK_HALF_DEF 8

`endif

//--- pkg/ssx_pkg.sv
// ssx_pkg: shared types of the serial port
// assumes nothing beyond a systemverilog compiler
package ssx_pkg;

    // frame sequencer state
    typedef enum logic [0:0] {
        SSX_FRM_IDLE = 1'b0,
        SSX_FRM_SHIFT = 1'b1
    } ssx_frm_t;

endpackage : ssx_pkg

//--- pkg/ssx_link_if.sv
// ssx_link_if: serial clock edge events between the edge finder and the core
// assumes both ends on sys_clk_i
`timescale 1ns/100ps
interface ssx_link_if;
    logic fall;
    logic rise;
    logic sdi;
    logic gen_en;
    logic ext_mode;

    modport edge_mp (output fall, output rise, output sdi, input gen_en, input ext_mode);
    modport core_mp (input fall, input rise, input sdi, output gen_en, output ext_mode);
endinterface : ssx_link_if

//--- rtl/ssx_sck_edge.sv
// ssx_sck_edge: synchronises the serial clock and data pins and finds clock edges,
// or makes the serial clock itself in internal clock operation
// assumes sck_pin_i and sdi_pin_i are asynchronous to sys_clk_i
`timescale 1ns/100ps
`include "ssx_map.svh"
module ssx_sck_edge #(
    parameter int SCK_HALF_CYC = `SSX_SCK_HALF_DEF
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic sck_pin_i,
    input wire logic sdi_pin_i,
    output logic sck_o,
    ssx_link_if.edge_mp lk
);

    logic sck_s1_ff, sck_s2_ff, sck_s3_ff;
    logic sdi_s1_ff, sdi_s2_ff;
    logic gen_ff, fall_ff, rise_ff;
    logic [15:0] div_ff;
    wire logic half_done = (div_ff == 16'(SCK_HALF_CYC - 1));
    // the generator only leaves the high level when asked, so it always parks high
    wire logic gen_run = lk.gen_en | ~gen_ff;

    ////////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers; the edge finder compares the second sck stage with a third
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {sck_s1_ff, sck_s2_ff, sck_s3_ff} <= 3'h7;
            {sdi_s1_ff, sdi_s2_ff} <= 2'h3;
        end else if (ce_i) begin
            {sck_s1_ff, sck_s2_ff, sck_s3_ff} <= {sck_pin_i, sck_s1_ff, sck_s2_ff};
            {sdi_s1_ff, sdi_s2_ff} <= {sdi_pin_i, sdi_s1_ff};
        end
    end

    // internal divider, idle high
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_ff <= 16'h0000;
            gen_ff <= 1'b1;
        end else if (ce_i) begin
            div_ff <= (gen_run && !half_done && !lk.ext_mode) ? div_ff + 16'h0001 : 16'h0000;
            if (gen_run && half_done && !lk.ext_mode) begin
                gen_ff <= ~gen_ff;
            end
        end
    end

    // one-cycle edge pulses from whichever clock source is selected
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fall_ff <= 1'b0;
            rise_ff <= 1'b0;
        end else if (ce_i) begin
            fall_ff <= lk.ext_mode ? (sck_s3_ff & ~sck_s2_ff) : (gen_run & half_done & gen_ff);
            rise_ff <= lk.ext_mode ? (~sck_s3_ff & sck_s2_ff) : (gen_run & half_done & ~gen_ff);
        end
    end

    assign lk.fall = fall_ff;
    assign lk.rise = rise_ff;
    assign lk.sdi = sdi_s2_ff;
    assign sck_o = gen_ff;

endmodule : ssx_sck_edge

//--- testbench/ssx_txrx_core_props.sv
// ssx_txrx_core_props: port-level checks of the serial port, bound to its top module
// assumes one sys_clk_i domain reset by arst_n_i, asynchronous and active low
`timescale 1ns/100ps
`include "ssx_map.svh"
module ssx_txrx_core_props #(
    parameter int SCK_HALF_CYC = `SSX_SCK_HALF_DEF
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic sck_i,
    input wire logic sck_o,
    input wire logic sck_oe_n_o,
    input wire logic sdi_i,
    input wire logic sdo_o,
    input wire logic irq_o
);
    logic req;
    logic ctl_wr;
    logic rd_ok;

    // decoded bus events; ctl_wr is a control write at its accepting edge
    assign req = avs_read_i | avs_write_i;
    assign rd_ok = avs_read_i & ~avs_waitrequest_o;
    assign ctl_wr = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0]
        & (avs_address_i == `SSX_OFF_CTRL);

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    ////////////////////////////////////////////////////////////////////////////////
    wait_first_a: assert property ($rose(req) |-> avs_waitrequest_o)
        else $error("request accepted with no wait cycle");
    wait_one_a: assert property ($rose(req) && ce_i ##1 ce_i |-> !avs_waitrequest_o)
        else $error("request not accepted after one wait cycle");
    idle_wait_a: assert property (!req |-> !avs_waitrequest_o)
        else $error("waitrequest high with no request");
    hole_zero_a: assert property (rd_ok && (avs_address_i[1:0] != 2'h0
        || avs_address_i == `SSX_OFF_TXB) |-> avs_readdata_o == 32'h0000_0000)
        else $error("unmapped or write-only read not zero");
    upper_zero_a: assert property (rd_ok |-> avs_readdata_o[31:8] == 24'h00_0000)
        else $error("upper read data bits not zero");
    oe_ctrl_a: assert property ($changed(sck_oe_n_o) |-> $past(ctl_wr))
        else $error("clock pin direction changed without control write");
    irq_once_a: assert property (irq_o |=> !irq_o)
        else $error("interrupt pulse longer than one cycle");
    irq_end_a: assert property (irq_o && sck_oe_n_o |-> sck_i)
        else $error("interrupt not at end of a frame");
    inhibit_park_a: assert property (ctl_wr && avs_writedata_i[`SSX_C_INH] |=> sdo_o [*4])
        else $error("serial data not parked high after inhibit");
    ce_wait_a: assert property (req && !ce_i |-> avs_waitrequest_o)
        else $error("request accepted while clock enable was low");
    ce_freeze_a: assert property (!ce_i |=> $stable(sdo_o) && $stable(irq_o)
        && $stable(avs_readdata_o))
        else $error("state moved while clock enable was low");
endmodule : ssx_txrx_core_props

bind ssx_txrx_core ssx_txrx_core_props #(.SCK_HALF_CYC(SCK_HALF_CYC)) u_props (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .sck_i(sck_i), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o), .sdi_i(sdi_i),
    .sdo_o(sdo_o), .irq_o(irq_o));

//--- testbench/ssx_peer.sv
// ssx_peer: external serial peer that makes the serial clock and swaps bytes msb first
// assumes the device shifts out on falling and samples on rising clock edges
`timescale 1ns/100ps
module ssx_peer (
    output logic sck_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    logic [7:0] got;

    // clock stands high between frames
    initial begin
        sck_o = 1'b1;
        sdi_o = 1'b0;
        got = 8'h00;
    end

    // one frame of eight 160 ns clocks; the 3 ns offset keeps edges off sys_clk_i
    task automatic xfer(input logic [7:0] tx);
        #3;
        for (int i = 7; i >= 0; i--) begin
            sck_o = 1'b0;
            sdi_o = tx[i];
            #80;
            sck_o = 1'b1;
            #79;
            got = {got[6:0], sdo_i}; // late in the high half, after the synchroniser delay
            #1;
        end
        sdi_o = ~sdi_o; // released line has no pull, so do not leave the last bit
    endtask : xfer
endmodule : ssx_peer

//--- testbench/ssx_txrx_core_tb.sv
// ssx_txrx_core_tb: register-level tests of the serial port against an external peer
// assumes ssx_peer drives the serial clock while the external clock bit is set
`timescale 1ns/100ps
`include "ssx_map.svh"
module ssx_txrx_core_tb;
    localparam logic [3:0] ctl = `SSX_OFF_CTRL;
    localparam logic [3:0] sta = `SSX_OFF_STAT;
    localparam logic [3:0] rxb = `SSX_OFF_RXB;
    localparam logic [3:0] txb = `SSX_OFF_TXB;
    localparam logic [31:0] all = 32'hFFFF_FFFF;
    localparam logic [31:0] no_txe = 32'hFFFF_FFFB; // empty flag reading left open
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hF;
    logic ce = 1'b1;
    logic [31:0] rdat;
    logic [31:0] q;
    logic wreq;
    logic sck_dev;
    logic oe_n;
    logic sdo;
    logic irq;
    logic pk_sck;
    logic pk_sdi;
    wire sck_w;
    int err_count = 0;
    int check_count = 0;
    int irq_n = 0;

    // clock, shared clock wire (device drives it while oe_n is low), interrupt count
    always #10 clk = ~clk;
    assign sck_w = oe_n ? pk_sck : sck_dev;
    always @(posedge clk) if (irq === 1'b1) irq_n++;

    ssx_txrx_core #(.SCK_HALF_CYC(4)) dut (
        .sys_clk_i(clk), .arst_n_i(rst_n), .ce_i(ce), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .sck_i(sck_w), .sck_o(sck_dev),
        .sck_oe_n_o(oe_n), .sdi_i(pk_sdi), .sdo_o(sdo), .irq_o(irq));
    ssx_peer peer (.sck_o(pk_sck), .sdi_o(pk_sdi), .sdo_i(sdo));

    ////////////////////////////////////////////////////////////////////////////////
    // masked compare; unknown bits inside the mask never match
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        check_count++;
        if ((got & m) !== (exp & m)) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one avalon access, held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clk); // launch just after an edge even when called off one
        adr <= a;
        wd <= d;
        be <= b;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        while (wreq !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) chk(32'h0, 32'h1, all);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic wrr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask : wrr

    task automatic rdc(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(q, e, m);
    endtask : rdc

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    // watchdog: the tests take well under 10000 system clocks
    initial begin
        #400000;
        err_count++;
        close_out;
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({31'h0, sdo}, 32'h1, all);
        rdc(ctl, 32'h0, all);
        // refused accesses: status write, unmapped read, write with no byte enable
        wrr(sta, 32'hFF);
        rdc(sta, 32'h4, all);
        rdc(4'h2, 32'h0, all);
        bus(1'b1, ctl, 32'h19, 4'h0);
        rdc(ctl, 32'h0, all);
        // plain frame; run cleared mid-frame must still finish it
        // clock enable low holds the control write in its wait state
        fork
            wrr(ctl, 32'h19);
            begin
                ce <= 1'b0;
                repeat (6) @(posedge clk);
                ce <= 1'b1;
            end
        join
        rdc(ctl, 32'h19, all);
        wrr(txb, 32'hA5);
        fork
            peer.xfer(8'h3C);
            begin
                repeat (30) @(posedge clk);
                rdc(sta, 32'h3, no_txe);
                wrr(ctl, 32'h18);
            end
        join
        repeat (10) @(posedge clk);
        chk({24'h0, peer.got}, 32'hA5, all);
        chk(irq_n, 32'h1, all);
        chk({31'h0, sdo}, 32'h1, all);
        rdc(sta, 32'h8, no_txe);
        rdc(rxb, 32'h3C, all);
        rdc(sta, 32'h0, no_txe);
        // run set with no transmit byte: underrun flagged at frame start
        wrr(ctl, 32'h19);
        fork
            peer.xfer(8'h5A);
            begin
                repeat (20) @(posedge clk);
                rdc(sta, 32'h13, no_txe);
                chk(irq_n, 32'h1, all);
            end
        join
        repeat (10) @(posedge clk);
        chk({24'h0, peer.got}, 32'hFF, all);
        chk(irq_n, 32'h2, all);
        rdc(rxb, 32'h5A, all);
        rdc(sta, 32'h11, no_txe);
        wrr(ctl, 32'h1B);
        rdc(ctl, 32'h1A, all);
        rdc(sta, 32'h0, no_txe);
        rdc(rxb, 32'h0, all);
        wrr(ctl, 32'h18);
        // receive buffer left unread across three frames
        wrr(ctl, 32'h19);
        wrr(txb, 32'h81);
        peer.xfer(8'h11);
        wrr(txb, 32'h42);
        peer.xfer(8'h22);
        repeat (10) @(posedge clk);
        chk({24'h0, peer.got}, 32'h42, all);
        rdc(sta, 32'h29, no_txe);
        chk(irq_n, 32'h4, all);
        peer.xfer(8'h33);
        repeat (10) @(posedge clk);
        chk(irq_n, 32'h4, all);
        chk({24'h0, peer.got}, 32'hFF, all);
        rdc(sta, 32'h39, no_txe);
        // recovery: stop, then two buffer reads
        wrr(ctl, 32'h18);
        rdc(rxb, 32'h11, all);
        rdc(sta, 32'h38, no_txe);
        rdc(rxb, 32'h22, all);
        rdc(sta, 32'h10, no_txe);
        // with run cleared a peer frame must not start
        peer.xfer(8'h44);
        repeat (10) @(posedge clk);
        chk(irq_n, 32'h4, all);
        rdc(sta, 32'h10, no_txe);
        wrr(ctl, 32'h1A);
        rdc(sta, 32'h0, no_txe);
        // least significant bit first in both directions
        wrr(ctl, 32'h39);
        wrr(txb, 32'h01);
        peer.xfer(8'h03);
        repeat (10) @(posedge clk);
        chk({24'h0, peer.got}, 32'h80, all);
        chk(irq_n, 32'h5, all);
        rdc(rxb, 32'hC0, all);
        close_out;
    end
endmodule : ssx_txrx_core_tb
